// >>> hdl/subband_sample_serial_port.sv
// subband sample serial port: sends pre-synthesis samples, takes processed ones back
// assumes decoder supplies a sample pair per fs request and frame layer/mute flags
`timescale 1ns/1ps
module subband_sample_serial_port (
    // clock and reset
    input  wire logic                          clock,
    input  wire logic                          rst_b,
    // decoder side
    input  wire subband_port_pkg::sample_pair_t dec_pair,
    input  wire logic                          dec_layer2,
    input  wire logic                          dec_error,
    input  wire logic                          dec_mute,
    output logic                               pair_req_q,
    output subband_port_pkg::sample_pair_t     syn_pair_q,
    output logic                               syn_valid_q,
    output logic [4:0]                         syn_subband_q,
    // serial link, all driven here but the return line
    output logic                               subband_sck_q,
    output logic                               subband_ws_q,
    output logic                               subband_out_q,
    output logic                               subband_mute_flag_q,
    output logic                               subband_frame_mark_q,
    input  wire logic                          subband_return_in
);
    // bit clock divider state
    logic [2:0]  div_q;
    logic [2:0]  div_d;
    logic        div_wrap;
    // slot, subband and frame counters
    logic [5:0]  bit_q;
    logic [5:0]  bit_d;
    logic [4:0]  sb_q;
    logic [4:0]  sb_d;
    logic [10:0] fcnt_q;
    logic [10:0] fcnt_d;
    logic [10:0] frame_len;
    // transmit path
    logic [47:0] tx_q;
    logic [47:0] tx_d;
    logic        send_bit;
    logic        out_next;
    // receive path
    logic [23:0] rx_q;
    logic [23:0] rx_d;
    logic [23:0] rx_left_q;
    logic [4:0]  rx_sb_q;
    logic        rin_s1_q;
    logic        rin_s2_q;
    logic        take_bit;
    // frame mark and mute
    logic        in_mute_q;
    logic        mute_next;
    // timing decodes
    logic        fall_edge;
    logic        rise_edge;
    logic [4:0]  slot_pos;
    logic        pair_end;
    logic        left_end;
    logic        frame_last;
    logic        mark_time;
    logic        mark_on;
    logic        mark_off;
    logic        ws_next;
    logic        left_done;
    logic        right_done;

    // slot positions that carry sample bits on the output line
    function automatic logic is_sample_bit(input logic [4:0] pos);
        return pos <= subband_port_pkg::msb_pos;
    endfunction : is_sample_bit

    // slot positions of sample bits at rising sck, one bit behind
    function automatic logic is_return_bit(input logic [4:0] pos);
        return (pos >= 5'h01) && (pos <= subband_port_pkg::msb_pos + 5'h01);
    endfunction : is_return_bit

    // bit clock edges, half period of sck_half_div clocks
    assign div_wrap   = (div_q == 3'(subband_port_pkg::sck_half_div - 1));
    assign div_d      = div_wrap ? 3'h0 : div_q + 3'h1;
    assign fall_edge  = subband_sck_q && div_wrap;
    assign rise_edge  = !subband_sck_q && div_wrap;

    // slot and pair position
    assign slot_pos   = bit_q[4:0];
    assign bit_d      = bit_q + 6'h01;
    assign pair_end   = (bit_q == subband_port_pkg::bit_last);
    assign left_end   = (bit_q == {1'b0, subband_port_pkg::bit_last[4:0]});
    assign ws_next    = left_end ? 1'b1 : (pair_end ? 1'b0 : subband_ws_q);

    // frame length and frame position
    assign frame_len  = dec_layer2 ? 11'(subband_port_pkg::frame_l2)
                                   : 11'(subband_port_pkg::frame_l1);
    assign frame_last = (fcnt_q >= frame_len - 11'h001);
    assign fcnt_d     = frame_last ? 11'h000 : fcnt_q + 11'h001;
    assign sb_d       = frame_last ? 5'h00 : sb_q + 5'h01;

    // mark and flag moments, one sck before ws falls
    assign mark_time  = (bit_q == subband_port_pkg::mark_bit);
    assign mark_on    = mark_time && frame_last;
    assign mark_off   = mark_time && (fcnt_q == 11'h000);
    assign mute_next  = dec_error || dec_mute;

    // transmit selection
    assign send_bit   = is_sample_bit(slot_pos);
    assign out_next   = send_bit ? tx_q[47] : 1'b0;
    assign tx_d       = pair_end ? (in_mute_q ? 48'h0 : dec_pair)
                                 : (send_bit ? {tx_q[46:0], 1'b0} : tx_q);

    // receive selection
    assign take_bit   = is_return_bit(slot_pos);
    assign rx_d       = {rx_q[22:0], rin_s2_q};
    assign left_done  = (bit_q == 6'h19);
    assign right_done = (bit_q == 6'h39);

    // divider count
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            div_q <= 3'h0;
        end else begin
            div_q <= div_d;
        end
    end

    // bit clock at 64 fs
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            subband_sck_q <= 1'b0;
        end else if (div_wrap) begin
            subband_sck_q <= !subband_sck_q;
        end
    end

    // bit position within the pair
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            bit_q <= 6'h00;
        end else if (fall_edge) begin
            bit_q <= bit_d;
        end
    end

    // word select, low left, high right
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            subband_ws_q <= 1'b0;
        end else if (fall_edge) begin
            subband_ws_q <= ws_next;
        end
    end

    // subband index of the pair on the line
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sb_q <= 5'h00;
        end else if (fall_edge && pair_end) begin
            sb_q <= sb_d;
        end
    end

    // pair count in frame, starts on a frame's last pair
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fcnt_q <= 11'h7ff;
        end else if (fall_edge && pair_end) begin
            fcnt_q <= fcnt_d;
        end
    end

    // transmit shift register, zeros while muted
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tx_q <= 48'h0;
        end else if (fall_edge) begin
            tx_q <= tx_d;
        end
    end

    // serial data, msb one sck after ws change, zero pad
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            subband_out_q <= 1'b0;
        end else if (fall_edge) begin
            subband_out_q <= out_next;
        end
    end

    // pair request, set on the same edge that loads the pair
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pair_req_q <= 1'b0;
        end else begin
            pair_req_q <= fall_edge && pair_end;
        end
    end

    // mute state for the coming frame
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            in_mute_q <= 1'b0;
        end else if (fall_edge && mark_on) begin
            in_mute_q <= mute_next;
        end
    end

    // mute flag, changes only with the mark rise
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            subband_mute_flag_q <= 1'b0;
        end else if (fall_edge && mark_on) begin
            subband_mute_flag_q <= mute_next;
        end
    end

    // frame mark over the subband zero pair
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            subband_frame_mark_q <= 1'b0;
        end else if (fall_edge && mark_on) begin
            subband_frame_mark_q <= 1'b1;
        end else if (fall_edge && mark_off) begin
            subband_frame_mark_q <= 1'b0;
        end
    end

    // return line synchroniser
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rin_s1_q <= 1'b0;
            rin_s2_q <= 1'b0;
        end else begin
            rin_s1_q <= subband_return_in;
            rin_s2_q <= rin_s1_q;
        end
    end

    // return shift register, pad bits ignored
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rx_q <= 24'h0;
        end else if (rise_edge && take_bit) begin
            rx_q <= rx_d;
        end
    end

    // returned left sample
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rx_left_q <= 24'h0;
        end else if (rise_edge && left_done) begin
            rx_left_q <= rx_q;
        end
    end

    // subband index of the returned pair
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rx_sb_q <= 5'h00;
        end else if (rise_edge && left_done) begin
            rx_sb_q <= sb_q;
        end
    end

    // returned pair to the synthesis filter
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            syn_pair_q <= '0;
        end else if (rise_edge && right_done) begin
            syn_pair_q <= '{left: rx_left_q, right: rx_q};
        end
    end

    // returned pair strobe
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            syn_valid_q <= 1'b0;
        end else begin
            syn_valid_q <= rise_edge && right_done;
        end
    end

    // returned pair subband
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            syn_subband_q <= 5'h00;
        end else if (rise_edge && right_done) begin
            syn_subband_q <= rx_sb_q;
        end
    end
endmodule : subband_sample_serial_port

// >>> hdl/subband_port_pkg.sv
// subband serial port constants and carrier types
// assumes 100 MHz system clock; sample timing derived inside the port
package subband_port_pkg;
    localparam int unsigned sck_per_fs   = 64;
    localparam int unsigned slot_bits    = 32;
    localparam int unsigned sample_bits  = 24;
    localparam int unsigned pad_bits     = 8;
    localparam int unsigned subbands     = 32;
    localparam int unsigned frame_l1     = 384;
    localparam int unsigned frame_l2     = 1152;
    localparam int unsigned sck_half_div = 4;
    localparam logic [5:0]  bit_last     = 6'h3f;
    localparam logic [5:0]  mark_bit     = 6'h3e;
    localparam logic [4:0]  msb_pos      = 5'h17;

    typedef struct packed {
        logic signed [23:0] left;
        logic signed [23:0] right;
    } sample_pair_t;
endpackage : subband_port_pkg

// >>> bench/subband_port_monitor.sv
// timing checker for the subband serial port outputs
// bound onto the port module, sees its ports only
`timescale 1ns/1ps
module subband_port_monitor (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // serial link
    input wire logic subband_sck_q,
    input wire logic subband_ws_q,
    input wire logic subband_out_q,
    input wire logic subband_mute_flag_q,
    input wire logic subband_frame_mark_q
);
    logic [9:0] clk_n_q;
    logic [5:0] bit_q;
    logic       seen_q;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // clocks per pair and bit position in slot
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            clk_n_q <= 10'h000;
            bit_q   <= 6'h00;
            seen_q  <= 1'b0;
        end else begin
            clk_n_q <= $rose(subband_ws_q) ? 10'h001 : clk_n_q + 10'h001;
            bit_q   <= $changed(subband_ws_q) ? 6'h00 : bit_q + 6'($fell(subband_sck_q));
            seen_q  <= seen_q | $rose(subband_ws_q);
        end
    end
    sck_high_a: assert property (
        $rose(subband_sck_q) |-> subband_sck_q [*4] ##1 !subband_sck_q) else $error("sck high");
    pair_len_a: assert property (
        $rose(subband_ws_q) && seen_q |-> clk_n_q == 10'h200) else $error("pair length");
    ws_edge_a: assert property (
        $changed(subband_ws_q) |-> $fell(subband_sck_q)) else $error("ws edge");
    data_edge_a: assert property (
        $changed(subband_out_q) |-> $fell(subband_sck_q)) else $error("data edge");
    slot_pad_a: assert property (
        seen_q && !$fell(subband_sck_q) && (bit_q > 6'h18 || bit_q == 6'h00) |-> !subband_out_q)
        else $error("pad");
    slot_len_a: assert property (
        seen_q && bit_q == 6'h1f && $fell(subband_sck_q) |-> $changed(subband_ws_q))
        else $error("slot length");
    mark_time_a: assert property (
        $changed(subband_frame_mark_q) |-> ##8 $fell(subband_ws_q)) else $error("mark time");
    flag_frame_a: assert property (
        $changed(subband_mute_flag_q) |-> $rose(subband_frame_mark_q)) else $error("flag");
endmodule : subband_port_monitor
bind subband_sample_serial_port subband_port_monitor i_mon (.clock(clock), .rst_b(rst_b),
    .subband_sck_q(subband_sck_q), .subband_ws_q(subband_ws_q), .subband_out_q(subband_out_q),
    .subband_mute_flag_q(subband_mute_flag_q), .subband_frame_mark_q(subband_frame_mark_q));

// >>> bench/subband_partner.sv
// far-side processor model: loops samples back, junk in pad bits
// assumes bit clock and word select come from the port
`timescale 1ns/1ps
module subband_partner (
    // serial link
    input  wire logic subband_sck_q,
    input  wire logic subband_ws_q,
    input  wire logic subband_out_q,
    output logic      subband_return_in
);
    logic [5:0] n  = 6'h00;
    logic       wl = 1'b0;
    always @(negedge subband_sck_q) begin
        #1;
        n = (subband_ws_q != wl) ? 6'h00 : n + 6'h01;
        wl = subband_ws_q;
    end
    assign subband_return_in = (n == 6'h00 || n > 6'h18) ? 1'b1 : subband_out_q;
endmodule : subband_partner

// >>> bench/tb.sv
// bench for the subband serial port, looped back through the partner
// assumes steady layer and mute flags, dec_error raised only by the mute test
`timescale 1ns/1ps
module tb;
    localparam logic [47:0] pa = 48'h6a5c3f_95a3c1;
    localparam logic [47:0] pb = 48'h800001_7ffffe;
    logic                           clock = 1'b0;
    logic                           rst_b = 1'b0;
    logic                           lo = 1'b0;
    logic                           er = 1'b0;
    logic [4:0]                     ssb;
    subband_port_pkg::sample_pair_t dp = pa;
    subband_port_pkg::sample_pair_t sp;
    logic                           sv, sck, ws, so, fl, mk, ri;
    int                             err_count = 0;
    int                             num_checks = 0;
    int                             cyc = 0;
    always #5 clock = ~clock;
    subband_sample_serial_port i_dut (.clock(clock), .rst_b(rst_b), .dec_pair(dp),
        .dec_layer2(lo), .dec_error(er), .dec_mute(lo), .pair_req_q(), .syn_pair_q(sp),
        .syn_valid_q(sv), .syn_subband_q(ssb), .subband_sck_q(sck), .subband_ws_q(ws),
        .subband_out_q(so), .subband_mute_flag_q(fl), .subband_frame_mark_q(mk),
        .subband_return_in(ri));
    subband_partner i_far (.subband_sck_q(sck), .subband_ws_q(ws), .subband_out_q(so),
        .subband_return_in(ri));
    task automatic ck(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : ck
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            wrap_up();
        end
    end
    task automatic t_mark;
        logic [63:0] n;
        n = 64'h0;
        @(posedge mk);
        forever begin
            @(posedge sck);
            if (mk !== 1'b1) break;
            n++;
        end
        ck(n, 64'h40);
        ck({63'h0, fl}, 64'h0);
        ck({59'h0, ssb}, 64'h0);
    endtask : t_mark
    task automatic t_mute;
        @(negedge clock);
        rst_b = 1'b0;
        er    = 1'b1;
        repeat (2) @(negedge clock);
        rst_b = 1'b1;
        @(posedge mk);
        @(posedge sck);
        ck({63'h0, fl}, 64'h1);
        t_slots(48'h0);
    endtask : t_mute
    task automatic t_slots(input logic [47:0] exp);
        logic [63:0] b;
        logic [63:0] w;
        repeat (2) @(negedge ws);
        for (int i = 63; i >= 0; i--) begin
            @(posedge sck);
            b[i] = so;
            w[i] = ws;
        end
        ck({16'h0, b[62:39], b[30:7]}, {16'h0, exp});
        ck({48'h0, b[63], b[38:31], b[6:0]}, 64'h0);
        ck(w, 64'h00000000ffffffff);
    endtask : t_slots
    task automatic t_ret(input logic [47:0] exp);
        repeat (3) @(posedge sv);
        @(negedge clock);
        ck({16'h0, sp}, {16'h0, exp});
    endtask : t_ret
    initial begin
        repeat (16) @(posedge clock);
        @(negedge clock);
        rst_b = 1'b1;
        t_mark();
        t_slots(pa);
        t_ret(pa);
        @(negedge clock);
        dp = pb;
        t_slots(pb);
        t_ret(pb);
        t_mute();
        wrap_up();
    end
endmodule : tb
